// >>> rtl/rtc_pkg.sv
/*
 * Constants for the tag hardware-configuration block: byte addresses of
 * the configuration area, field positions, values that apply when the
 * area is invalid, and timeout base units.
 * Assumes a 100 MHz system clock and a byte-wide memory read port.
 */
package rtc_pkg;

  // Byte addresses of the configuration bytes in the memory array
  localparam logic [9:0] ADDR_HW_SET_LO  = 10'h3EE;
  localparam logic [9:0] ADDR_HW_SET_HI  = 10'h3EF;
  localparam logic [9:0] ADDR_TUNNEL_TMO = 10'h3FC;
  localparam logic [9:0] ADDR_HOST_LINK  = 10'h3FD;
  localparam logic [9:0] ADDR_IRQ_START  = 10'h3D5;
  localparam logic [9:0] ADDR_IRQ_END    = 10'h3D6;
  localparam int         FETCH_COUNT     = 6;

  // Values that apply before fetch or while the area is invalid
  localparam logic [7:0] RST_HW_SET_LO  = 8'h0F;
  localparam logic [7:0] RST_HW_SET_HI  = 8'h54;
  localparam logic [7:0] RST_TUNNEL_TMO = 8'h47;
  localparam logic [7:0] RST_HOST_LINK  = 8'hA0;
  localparam logic [7:0] RST_IRQ_START  = 8'h00;
  localparam logic [7:0] RST_IRQ_END    = 8'h3F;

  // Field positions in the first hardware settings byte
  localparam int POS_ACCESS_TABLE = 7;
  localparam int POS_WAIT_EXT     = 6;
  localparam int POS_TYPEB_RESTR  = 5;
  localparam int POS_ID_SOURCE    = 4;
  localparam int POS_RATE_LIMIT   = 3;

  // Exponent ranges and fallbacks for the tunnel timeouts, and the block bound limit
  localparam logic [3:0] QUERY_EXP_MAX = 4'h8;
  localparam logic [3:0] QUERY_EXP_DEF = 4'h4;
  localparam logic [3:0] ANSWER_EXP_MAX = 4'hC;
  localparam logic [3:0] ANSWER_EXP_DEF = 4'h7;
  localparam logic [7:0] BLOCK_MAX      = 8'h3F;

  // Timeout base units and the clock rate
  localparam int CLK_MHZ         = 100;
  localparam int TUNNEL_BASE_US  = 1024;
  localparam int SCL_GAP_BASE_US = 6160;
  localparam int RESP_BASE_US    = 24600;
  localparam int TUNNEL_BASE_CYC = TUNNEL_BASE_US * CLK_MHZ;
  localparam int SCL_GAP_CYC     = SCL_GAP_BASE_US * CLK_MHZ;
  localparam int RESP_BASE_CYC   = RESP_BASE_US * CLK_MHZ;

  // Protocol select codes
  localparam logic [2:0] PROTO_JIS      = 3'b001;
  localparam logic [2:0] PROTO_B        = 3'b010;
  localparam logic [2:0] PROTO_JIS_B    = 3'b011;
  localparam logic [2:0] PROTO_A        = 3'b100;
  localparam logic [2:0] PROTO_AB       = 3'b110;
  localparam logic [2:0] PROTO_ALL      = 3'b111;

  // TypeB rate caps
  localparam logic [1:0] RATE_106  = 2'h0;
  localparam logic [1:0] RATE_424  = 2'h2;
  localparam logic [1:0] RATE_NONE = 2'h3;

  typedef enum logic [1:0] {
    RTC_ST_IDLE  = 2'b00,
    RTC_ST_ISSUE = 2'b01,
    RTC_ST_WAIT  = 2'b10,
    RTC_ST_READY = 2'b11
  } rtc_state_t;

endpackage : rtc_pkg

// >>> rtl/rtc_hw_config.sv
/*
 * Hardware-configuration register bank of a dual-interface tag: fetches
 * the configuration bytes after reset or self-reset, decodes them, runs
 * the tunnel and serial-link timeouts and drives the interrupt pin.
 * Assumes a byte-wide memory read port and event pulses on sys_clk_i;
 * the serial clock pin is asynchronous and is synchronised here.
 */
// Notes on behaviour
// - wait-extension bit gates extension request block
// - TypeB restrict bit caps 424k when unlimited
// - identifier source bit selects stored or zero
// - rate-limit bit caps TypeB 106k, JIS 212k
// - protocol select enables only listed interfaces
// - second byte bits 6:0 give slave address
// - tunnel byte: query upper, answer lower nibble
// - query wait 1024us times two power exponent
// - answer wait 1024us times two power exponent
// - out-of-range tunnel exponent uses its default
// - link byte: gap, response, interrupt selects
// - SCL gap limit 6.16ms times power
// - response wait 24.6ms times power, also divided; code only multiplies, by 1 to 8
// - four select bits enable extra interrupt sources
// - extra sources add to always-on interrupts
// - write interrupt at memory write start
// - read interrupt after response, in block range
// - block bounds over 63 use defaults, end below start uses start
// - new parameters apply only after reset
// - bit seven selects access-rights table
`timescale 1ns/1ps
module rtc_hw_config #(
  parameter int TUNNEL_CYC = rtc_pkg::TUNNEL_BASE_CYC,
  parameter int SCL_CYC    = rtc_pkg::SCL_GAP_CYC,
  parameter int RESP_CYC   = rtc_pkg::RESP_BASE_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       self_reset_i,
  // Memory array read port
  output logic [9:0]      cfg_rd_addr_o,
  output logic            cfg_rd_en_o,
  input  wire logic [7:0] cfg_rd_data_i,
  input  wire logic       cfg_rd_valid_i,
  input  wire logic       cfg_area_valid_i,
  // Decoded settings
  output logic            cfg_ready_o,
  output logic            access_table_select_o,
  output logic            wait_extension_enable_o,
  output logic            card_identifier_source_o,
  output logic            jis_enable_o,
  output logic            typea_enable_o,
  output logic            typeb_enable_o,
  output logic            auto_detect_o,
  output logic [1:0]      typeb_max_rate_o,
  output logic            jis_rate_capped_o,
  output logic [6:0]      serial_slave_address_o,
  output logic [5:0]      read_irq_start_block_o,
  output logic [5:0]      read_irq_end_block_o,
  // Interrupt sources and acknowledge
  input  wire logic       host_done_i,
  input  wire logic       tunnel_event_i,
  input  wire logic       field_detect_i,
  input  wire logic       rf_tx_done_i,
  input  wire logic       rf_write_start_i,
  input  wire logic       rf_read_done_i,
  input  wire logic [5:0] rf_read_block_i,
  input  wire logic       irq_ack_i,
  output logic            interrupt_out_n_o,
  // Timeout windows
  input  wire logic       query_open_i,
  input  wire logic       query_seen_i,
  input  wire logic       answer_open_i,
  input  wire logic       answer_seen_i,
  input  wire logic       scl_i,
  input  wire logic       link_busy_i,
  input  wire logic       resp_open_i,
  input  wire logic       resp_seen_i,
  output logic [3:0]      timeout_o
);

  // Holding registers for the fetched bytes
  logic [7:0] raw_q [rtc_pkg::FETCH_COUNT];
  logic [7:0] raw_d [rtc_pkg::FETCH_COUNT];
  logic [2:0] idx_q, idx_d;
  rtc_pkg::rtc_state_t st_q, st_d;
  logic [9:0] addr_list [rtc_pkg::FETCH_COUNT];
  logic [7:0] def_list  [rtc_pkg::FETCH_COUNT];

  // Fetch order and fallback values
  assign addr_list = '{rtc_pkg::ADDR_HW_SET_LO, rtc_pkg::ADDR_HW_SET_HI,
                       rtc_pkg::ADDR_TUNNEL_TMO, rtc_pkg::ADDR_HOST_LINK,
                       rtc_pkg::ADDR_IRQ_START, rtc_pkg::ADDR_IRQ_END};
  assign def_list  = '{rtc_pkg::RST_HW_SET_LO, rtc_pkg::RST_HW_SET_HI,
                       rtc_pkg::RST_TUNNEL_TMO, rtc_pkg::RST_HOST_LINK,
                       rtc_pkg::RST_IRQ_START, rtc_pkg::RST_IRQ_END};

  // Fetch sequencer: bytes change only here, at reset or self-reset
  always_comb begin
    st_d  = st_q;
    idx_d = idx_q;
    raw_d = raw_q;
    unique case (st_q)
      rtc_pkg::RTC_ST_IDLE: begin
        idx_d = 3'h0;
        st_d  = rtc_pkg::RTC_ST_ISSUE;
      end
      rtc_pkg::RTC_ST_ISSUE: begin
        st_d = rtc_pkg::RTC_ST_WAIT;
      end
      rtc_pkg::RTC_ST_WAIT: begin
        if (cfg_rd_valid_i) begin
          raw_d[idx_q] = cfg_area_valid_i ? cfg_rd_data_i
                                          : def_list[idx_q];
          if (idx_q == 3'(rtc_pkg::FETCH_COUNT - 1)) begin
            st_d = rtc_pkg::RTC_ST_READY;
          end else begin
            idx_d = idx_q + 3'h1;
            st_d  = rtc_pkg::RTC_ST_ISSUE;
          end
        end
      end
      rtc_pkg::RTC_ST_READY: begin
        if (self_reset_i) begin
          st_d = rtc_pkg::RTC_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q  <= rtc_pkg::RTC_ST_IDLE;
      idx_q <= 3'h0;
      raw_q <= '{rtc_pkg::RST_HW_SET_LO, rtc_pkg::RST_HW_SET_HI,
                 rtc_pkg::RST_TUNNEL_TMO, rtc_pkg::RST_HOST_LINK,
                 rtc_pkg::RST_IRQ_START, rtc_pkg::RST_IRQ_END};
    end else begin
      st_q  <= st_d;
      idx_q <= idx_d;
      raw_q <= raw_d;
    end
  end

  assign cfg_rd_addr_o = addr_list[idx_q];
  assign cfg_rd_en_o   = (st_q == rtc_pkg::RTC_ST_ISSUE);
  assign cfg_ready_o   = (st_q == rtc_pkg::RTC_ST_READY);

  // Field views of the held bytes
  logic [7:0] hw_lo, hw_hi, tnl, lnk;
  logic [3:0] q_exp, a_exp;
  logic [1:0] gap_exp, resp_exp;
  logic [3:0] extra_irq_sel;
  logic [7:0] blk_s, blk_e;
  assign hw_lo = raw_q[0];
  assign hw_hi = raw_q[1];
  assign tnl   = raw_q[2];
  assign lnk   = raw_q[3];
  // Tunnel exponents with fallback
  assign q_exp = (tnl[7:4] > rtc_pkg::QUERY_EXP_MAX) ?
                 rtc_pkg::QUERY_EXP_DEF : tnl[7:4];
  assign a_exp = (tnl[3:0] > rtc_pkg::ANSWER_EXP_MAX) ?
                 rtc_pkg::ANSWER_EXP_DEF : tnl[3:0];
  // Serial-link byte fields
  assign gap_exp       = lnk[7:6];
  assign resp_exp      = lnk[5:4];
  assign extra_irq_sel = lnk[3:0];
  // Read-interrupt block range clamp
  assign blk_s = (raw_q[4] > rtc_pkg::BLOCK_MAX) ?
                 rtc_pkg::RST_IRQ_START : raw_q[4];
  assign blk_e = (raw_q[5] > rtc_pkg::BLOCK_MAX) ?
                 rtc_pkg::RST_IRQ_END : raw_q[5];

  // Decoded settings, registered
  logic [3:0] proto_d, proto_q;
  logic [1:0] brate_d, brate_q;
  logic [5:0] bs_d, be_d, bs_q, be_q;
  always_comb begin
    unique case (hw_lo[2:0])
      rtc_pkg::PROTO_JIS:   proto_d = 4'b0001;
      rtc_pkg::PROTO_B:     proto_d = 4'b0100;
      rtc_pkg::PROTO_JIS_B: proto_d = 4'b1101;
      rtc_pkg::PROTO_A:     proto_d = 4'b0010;
      rtc_pkg::PROTO_AB:    proto_d = 4'b1110;
      rtc_pkg::PROTO_ALL:   proto_d = 4'b1111;
      default:              proto_d = 4'b0000; // Undefined: all off
    endcase
    if (hw_lo[rtc_pkg::POS_RATE_LIMIT]) begin
      brate_d = rtc_pkg::RATE_106;
    end else if (hw_lo[rtc_pkg::POS_TYPEB_RESTR]) begin
      brate_d = rtc_pkg::RATE_424;
    end else begin
      brate_d = rtc_pkg::RATE_NONE;
    end
    bs_d = blk_s[5:0];
    be_d = (blk_e < blk_s) ? blk_s[5:0] : blk_e[5:0];
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      proto_q <= 4'b1111;
      brate_q <= rtc_pkg::RATE_106;
      bs_q    <= rtc_pkg::RST_IRQ_START[5:0];
      be_q    <= rtc_pkg::RST_IRQ_END[5:0];
    end else begin
      proto_q <= proto_d;
      brate_q <= brate_d;
      bs_q    <= bs_d;
      be_q    <= be_d;
    end
  end

  // Settings outputs
  assign access_table_select_o    = hw_lo[rtc_pkg::POS_ACCESS_TABLE];
  assign wait_extension_enable_o  = hw_lo[rtc_pkg::POS_WAIT_EXT];
  assign card_identifier_source_o = hw_lo[rtc_pkg::POS_ID_SOURCE];
  assign jis_rate_capped_o        = hw_lo[rtc_pkg::POS_RATE_LIMIT];
  assign serial_slave_address_o   = hw_hi[6:0];
  assign jis_enable_o             = proto_q[0];
  assign typea_enable_o           = proto_q[1];
  assign typeb_enable_o           = proto_q[2];
  assign auto_detect_o            = proto_q[3];
  assign typeb_max_rate_o         = brate_q;
  assign read_irq_start_block_o   = bs_q;
  assign read_irq_end_block_o     = be_q;

  // Interrupt pending flag; a new event wins over acknowledge
  logic irq_ev, pend_d, pend_q, in_range;
  assign in_range = (rf_read_block_i >= bs_q) && (rf_read_block_i <= be_q);
  always_comb begin
    irq_ev = host_done_i | tunnel_event_i;
    irq_ev = irq_ev | (extra_irq_sel[3] & rf_write_start_i);
    irq_ev = irq_ev | (extra_irq_sel[2] & rf_read_done_i
                       & in_range);
    irq_ev = irq_ev | (extra_irq_sel[1] & rf_tx_done_i);
    irq_ev = irq_ev | (extra_irq_sel[0] & field_detect_i);
    pend_d = irq_ev | (pend_q & ~irq_ack_i);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign interrupt_out_n_o = ~pend_q;

  // Serial clock pin synchroniser and edge detect
  logic scl_m_q, scl_s_q, scl_p_q, scl_edge;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
    end
  end
  assign scl_edge = scl_s_q ^ scl_p_q;

  // Four timeout windows: query, answer, SCL gap, response
  logic [3:0]  t_open, t_close;
  logic [31:0] t_lim [4];
  logic [31:0] cnt_d [4];
  logic [31:0] cnt_q [4];
  logic [3:0]  act_d, act_q, tmo_d, tmo_q;
  assign t_open  = {resp_open_i, link_busy_i & scl_edge,
                    answer_open_i, query_open_i};
  assign t_close = {resp_seen_i, ~link_busy_i, answer_seen_i,
                    query_seen_i};
  assign t_lim[0] = 32'(TUNNEL_CYC) << q_exp;
  assign t_lim[1] = 32'(TUNNEL_CYC) << a_exp;
  assign t_lim[2] = 32'(SCL_CYC) << gap_exp;
  assign t_lim[3] = 32'(RESP_CYC) << resp_exp;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cnt_d[i] = cnt_q[i];
      act_d[i] = act_q[i];
      tmo_d[i] = 1'b0;
      if (t_open[i]) begin
        cnt_d[i] = 32'h0;
        act_d[i] = 1'b1;
      end else if (t_close[i]) begin
        act_d[i] = 1'b0;
      end else if (act_q[i]) begin
        if (cnt_q[i] >= t_lim[i] - 32'h1) begin
          act_d[i] = 1'b0;
          tmo_d[i] = 1'b1;
        end else begin
          cnt_d[i] = cnt_q[i] + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '{default: 32'h0};
      act_q <= 4'h0;
      tmo_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
      act_q <= act_d;
      tmo_q <= tmo_d;
    end
  end

  assign timeout_o = tmo_q;

endmodule : rtc_hw_config

// >>> testbench/rtc_hw_config_properties.sv
/*
 * Checker for the tag configuration bank: fetch, decode, interrupt pin
 * and tunnel timer relations.
 * Assumes it is bound to the ports of rtc_hw_config.
 */
`timescale 1ns/1ps
module rtc_hw_config_properties (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  // Fetch and decode
  input wire logic       cfg_rd_en_o,
  input wire logic       cfg_ready_o,
  input wire logic       jis_enable_o,
  input wire logic       typea_enable_o,
  input wire logic       typeb_enable_o,
  input wire logic       auto_detect_o,
  input wire logic [1:0] typeb_max_rate_o,
  input wire logic       jis_rate_capped_o,
  input wire logic [5:0] read_irq_start_block_o,
  input wire logic [5:0] read_irq_end_block_o,
  // Interrupt and timers
  input wire logic       host_done_i,
  input wire logic       tunnel_event_i,
  input wire logic       field_detect_i,
  input wire logic       rf_tx_done_i,
  input wire logic       rf_write_start_i,
  input wire logic       rf_read_done_i,
  input wire logic       irq_ack_i,
  input wire logic       interrupt_out_n_o,
  input wire logic       query_open_i,
  input wire logic [3:0] timeout_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // No event input active
  wire no_ev = ~|{host_done_i, tunnel_event_i, field_detect_i,
                  rf_tx_done_i, rf_write_start_i, rf_read_done_i};
  // Decode has settled once ready stood two cycles
  sequence settled_s; cfg_ready_o && $past(cfg_ready_o); endsequence

  fetch_pulse_a: assert property (
    cfg_rd_en_o |=> !cfg_rd_en_o) else $error("fetch enable held");
  ready_quiet_a: assert property (
    cfg_ready_o |-> !cfg_rd_en_o) else $error("fetch while ready");
  proto_auto_a: assert property (settled_s |-> auto_detect_o ==
    ((jis_enable_o + typea_enable_o + typeb_enable_o) > 2'd1))
    else $error("auto detect mismatch");
  rate_cap_a: assert property (settled_s |-> jis_rate_capped_o ==
    (typeb_max_rate_o == rtc_pkg::RATE_106)) else $error("rate cap");
  range_order_a: assert property (settled_s |->
    read_irq_end_block_o >= read_irq_start_block_o) else $error("range");
  irq_rise_a: assert property (
    host_done_i |=> !interrupt_out_n_o) else $error("irq not raised");
  irq_hold_a: assert property (
    !interrupt_out_n_o && !irq_ack_i |=> !interrupt_out_n_o)
    else $error("irq dropped without ack");
  irq_clear_a: assert property (
    irq_ack_i && no_ev |=> interrupt_out_n_o) else $error("irq not cleared");
  query_early_a: assert property (
    query_open_i |=> !timeout_o[0] [*2]) else $error("query timeout early");
  tmo_pulse_a: assert property (
    $rose(timeout_o[1]) |=> !timeout_o[1]) else $error("timeout held");

  ready_c: cover property ($rose(cfg_ready_o));
  irq_c: cover property ($fell(interrupt_out_n_o));
  tmo_c: cover property (timeout_o[0]);
endmodule : rtc_hw_config_properties

// >>> testbench/rtc_mem_model.sv
/*
 * Memory array model answering configuration byte requests.
 * Assumes one request at a time; slow_i stretches the answer.
 */
`timescale 1ns/1ps
module rtc_mem_model (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  // Read port
  input  wire logic       rd_en_i,
  input  wire logic [9:0] addr_i,
  output logic [7:0]      data_o,
  output logic            valid_o
);
  logic [7:0] mem [0:1023];
  logic [9:0] addr_q;
  logic [7:0] last_q;
  int         cnt_q;
  initial begin
    valid_o = 1'b0;
    data_o  = 8'h00;
    last_q  = 8'h00;
    cnt_q   = -1;
  end
  // Answer after a delay; idle data is the inverse of the last byte
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    data_o  <= ~last_q;
    if (rd_en_i) begin
      addr_q <= addr_i;
      cnt_q  <= slow_i ? 5 : 0;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end else if (cnt_q == 0) begin
      valid_o <= 1'b1;
      data_o  <= mem[addr_q];
      last_q  <= mem[addr_q];
      cnt_q   <= -1;
    end
  end
endmodule : rtc_mem_model

// >>> testbench/rtc_hw_config_test.sv
/*
 * Bench for the configuration bank: fetch, decode, interrupts, timers.
 * Assumes shortened timer bases of 4, 8 and 16 cycles.
 */
`timescale 1ns/1ps
module rtc_hw_config_test;
  logic sys_clk_i = 0, sys_rst_i = 1, self_reset_i = 0, slow = 0;
  logic cfg_area_valid_i = 0, irq_ack_i = 0, scl_i = 1, link_busy_i = 0;
  logic scl_run = 0, cfg_rd_en_o, cfg_rd_valid_i, cfg_ready_o;
  logic access_table_select_o, wait_extension_enable_o, jis_enable_o;
  logic card_identifier_source_o, typea_enable_o, typeb_enable_o;
  logic auto_detect_o, jis_rate_capped_o, interrupt_out_n_o;
  logic [9:0] cfg_rd_addr_o;
  logic [7:0] cfg_rd_data_i;
  logic [6:0] serial_slave_address_o;
  logic [5:0] read_irq_start_block_o, read_irq_end_block_o, evs = 0;
  logic [5:0] rf_read_block_i = 6'h10;
  logic [3:0] timeout_o, opn = 0, cls = 0;
  logic [1:0] typeb_max_rate_o;
  int fails = 0, check_count = 0, tc [4] = '{0, 0, 0, 0}, t;
  // Packed views of the decoded settings for comparison
  wire [9:0]  hw_view    = {access_table_select_o, wait_extension_enable_o,
                           card_identifier_source_o, jis_rate_capped_o,
                           typeb_max_rate_o, jis_enable_o, typea_enable_o,
                           typeb_enable_o, auto_detect_o};
  wire [3:0]  proto_view = {jis_enable_o, typea_enable_o, typeb_enable_o,
                           auto_detect_o};
  wire [11:0] range_view = {read_irq_start_block_o, read_irq_end_block_o};
  always #5 sys_clk_i = ~sys_clk_i;
  always #80 if (scl_run) scl_i = ~scl_i;
  // Count timeout pulses
  always @(posedge sys_clk_i)
    for (int k = 0; k < 4; k++) if (timeout_o[k] === 1'b1) tc[k]++;
  rtc_mem_model u_mem (.clk_i(sys_clk_i), .slow_i(slow),
    .rd_en_i(cfg_rd_en_o), .addr_i(cfg_rd_addr_o),
    .data_o(cfg_rd_data_i), .valid_o(cfg_rd_valid_i));
  rtc_hw_config #(.TUNNEL_CYC(4), .SCL_CYC(8), .RESP_CYC(16)) dut (
    .sys_clk_i, .sys_rst_i, .self_reset_i, .cfg_rd_addr_o, .cfg_rd_en_o,
    .cfg_rd_data_i, .cfg_rd_valid_i, .cfg_area_valid_i, .cfg_ready_o,
    .access_table_select_o, .wait_extension_enable_o,
    .card_identifier_source_o, .jis_enable_o, .typea_enable_o,
    .typeb_enable_o, .auto_detect_o, .typeb_max_rate_o, .jis_rate_capped_o,
    .serial_slave_address_o, .read_irq_start_block_o, .read_irq_end_block_o,
    .host_done_i(evs[0]), .tunnel_event_i(evs[1]), .field_detect_i(evs[2]),
    .rf_tx_done_i(evs[3]), .rf_write_start_i(evs[4]),
    .rf_read_done_i(evs[5]), .rf_read_block_i, .irq_ack_i,
    .interrupt_out_n_o, .query_open_i(opn[0]), .query_seen_i(cls[0]),
    .answer_open_i(opn[1]), .answer_seen_i(cls[1]), .scl_i, .link_busy_i,
    .resp_open_i(opn[3]), .resp_seen_i(cls[3]), .timeout_o);

  task conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // Compare one value
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bounded wait for the fetch to finish
  task wrdy;
    int n;
    n = 0;
    while (cfg_ready_o !== 1'b1 && n < 500) begin
      @(posedge sys_clk_i) #1 n++;
    end
    if (n == 500) begin
      fails++;
      conclude;
    end else begin
      @(posedge sys_clk_i) #1;
    end
  endtask : wrdy
  task fetch;
    @(posedge sys_clk_i) self_reset_i <= 1'b1;
    @(posedge sys_clk_i) self_reset_i <= 1'b0;
    #1 wrdy;
  endtask : fetch
  // Pulse one event, check pin, acknowledge
  task irq(input logic [5:0] v, input logic e);
    @(posedge sys_clk_i) evs <= v;
    @(posedge sys_clk_i) evs <= 6'h00;
    #1 chk("irq_pin", 16'(!e), 16'(interrupt_out_n_o));
    @(posedge sys_clk_i) irq_ack_i <= 1'b1;
    @(posedge sys_clk_i) irq_ack_i <= 1'b0;
    #1 chk("irq_clear", 16'h0001, 16'(interrupt_out_n_o));
  endtask : irq
  // Open a timer window and measure cycles to its timeout
  task tmo(input int i, input int lim);
    int n;
    n = 0;
    @(posedge sys_clk_i) opn[i] <= 1'b1;
    @(posedge sys_clk_i) opn[i] <= 1'b0;
    while (timeout_o[i] !== 1'b1 && n < 3000) begin
      @(posedge sys_clk_i) #1 n++;
    end
    chk("timer", 16'(lim), 16'(n));
  endtask : tmo

  initial begin
    #500000 fails++;
    conclude;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    wrdy;
    chk("dflt", 16'h004F, 16'(hw_view));
    chk("addr", 16'h0054, 16'(serial_slave_address_o));
    chk("range", 16'h003F, 16'(range_view));
    $display("test defaults done");
    cfg_area_valid_i <= 1'b1;
    u_mem.mem[10'h3EF] = 8'h2B;
    u_mem.mem[10'h3FC] = 8'h9D;
    u_mem.mem[10'h3FD] = 8'h9C;
    u_mem.mem[10'h3D5] = 8'h10;
    u_mem.mem[10'h3D6] = 8'h05;
    for (int c = 0; c < 8; c++) begin
      u_mem.mem[10'h3EE] = 8'hF0 | 8'(c);
      slow <= c[0];
      fetch;
      t = (c == 0 || c == 5) ? 0 :
          int'({c[0], c[2], c[1], $countones(3'(c)) > 1});
      chk("proto", 16'(t), 16'(proto_view));
    end
    chk("hw", 16'h03AF, 16'(hw_view));
    chk("addr", 16'h002B, 16'(serial_slave_address_o));
    chk("range", 16'h0410, 16'(range_view));
    $display("test decode done");
    for (int i = 0; i < 6; i++) irq(6'(1 << i), 1'(6'b110011 >> i));
    rf_read_block_i <= 6'h11;
    irq(6'h20, 1'b0);
    $display("test interrupts done");
    tmo(0, 64);
    tmo(1, 512);
    tmo(3, 32);
    u_mem.mem[10'h3FC] = 8'h23;
    u_mem.mem[10'h3EF] = 8'h11;
    chk("hold", 16'h002B, 16'(serial_slave_address_o));
    fetch;
    chk("new", 16'h0011, 16'(serial_slave_address_o));
    tmo(0, 16);
    tmo(1, 32);
    t = tc[0];
    @(posedge sys_clk_i) opn[0] <= 1'b1;
    @(posedge sys_clk_i) opn[0] <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    cls[0] <= 1'b1;
    @(posedge sys_clk_i) cls[0] <= 1'b0;
    repeat (60) @(posedge sys_clk_i);
    chk("closed", 16'(t), 16'(tc[0]));
    t = tc[2];
    link_busy_i <= 1'b1;
    scl_run = 1'b1;
    repeat (200) @(posedge sys_clk_i);
    chk("scl_run", 16'(t), 16'(tc[2]));
    scl_run = 1'b0;
    repeat (80) @(posedge sys_clk_i);
    chk("scl_stall", 16'(t + 1), 16'(tc[2]));
    link_busy_i <= 1'b0;
    $display("test timers done");
    conclude;
  end
endmodule : rtc_hw_config_test

bind rtc_hw_config rtc_hw_config_properties u_props (
  .sys_clk_i, .sys_rst_i, .cfg_rd_en_o, .cfg_ready_o, .jis_enable_o,
  .typea_enable_o, .typeb_enable_o, .auto_detect_o, .typeb_max_rate_o,
  .jis_rate_capped_o, .read_irq_start_block_o, .read_irq_end_block_o,
  .host_done_i, .tunnel_event_i, .field_detect_i, .rf_tx_done_i,
  .rf_write_start_i, .rf_read_done_i, .irq_ack_i, .interrupt_out_n_o,
  .query_open_i, .timeout_o);
